// file: adc_ctl_defs.vh
// constants for the pipelined converter output control block
// Contract
// - encode high when positive exceeds negative
// - track while low, freeze at rising edge
// - new sample on every encode rising edge
// - sample word appears five encode cycles later
// - adjacent stages work in opposite phases
// - align stage results, combine in correction
// - ten bit word, bit 9 most significant
// - range flag high on over or under range
// - normal: output enable low drives outputs
// - power down: hi-z, nap or sleep
// - config level picks coding and stabilizer
`ifndef ADC_CTL_DEFS_VH
`define ADC_CTL_DEFS_VH
`define WORD_W 10
`define IN_W 12
`define STAGES 5
`define HALF_STEPS 10
`define CODE_MAX 12'sh1ff
`define CODE_MIN -12'sh200
`define CODE_MID 10'h200
`define DIGIT_W 2
`define REG_STATUS 4'h0
`define REG_IRQ_EN 4'h4
`define REG_IRQ_CLR 4'h8
`define REG_STATE 4'hc
`define EV_W 3
`define EV_SAMPLE 0
`define EV_RANGE 1
`define EV_MODE 2
`define MODE_NORMAL 2'h0
`define MODE_NAP 2'h1
`define MODE_SLEEP 2'h2
`define CFG_OB_OFF 2'h0
`define CFG_OB_ON 2'h1
`define CFG_TC_ON 2'h2
`define CFG_TC_OFF 2'h3
`define ST_WORD_LSB 0
`define ST_RANGE_BIT 10
`define ST_MODE_LSB 11
`define ST_TWOS_BIT 13
`define ST_STAB_BIT 14
`endif

// file: adc_output_control.v
// converter pipeline, output drivers, mode pins and register slave
`timescale 1ns/1ps
`include "adc_ctl_defs.vh"
module adc_output_control (
    input wire CLK, // 250 MHz clock
    input wire RST_N, // synchronous reset, active low
    input wire ENCODE_POS, // encode input, positive
    input wire ENCODE_NEG, // encode input, negative
    input wire signed [11:0] ANALOG_IN, // digitized analog level, two's complement
    input wire POWER_DOWN_SELECT, // power-down select pin
    input wire OUTPUT_ENABLE_N, // output enable, active low
    input wire [1:0] CONFIG_LEVEL, // config pin level: 0, 1/3, 2/3, full
    output reg [9:0] SAMPLE_BITS, // sample word
    output reg [9:0] SAMPLE_BITS_OE, // drive enable per sample bit
    output reg RANGE_FLAG, // over/under range
    output reg RANGE_FLAG_OE, // drive enable for range flag
    output reg SAMPLE_STROBE, // data valid strobe
    output reg SAMPLE_STROBE_OE, // drive enable for strobe
    input wire [3:0] AVS_ADDRESS, // byte address
    input wire AVS_READ, // read request
    input wire AVS_WRITE, // write request
    input wire [31:0] AVS_WRITEDATA, // write data
    output reg [31:0] AVS_READDATA, // read data
    output reg AVS_WAITREQUEST, // stall
    output reg IRQ // level interrupt
);
    reg phase_prev_ff;
    reg [9:0] res_ff [0:9];
    reg [9:0] acc_ff [0:9];
    reg [9:0] ovr_ff;
    reg [9:0] held_code_ff;
    reg held_ovr_ff;
    reg [1:0] mode_ff;
    reg [`EV_W-1:0] status_ff;
    reg [`EV_W-1:0] irq_en_ff;
    wire phase_now;
    wire rise;
    wire fall;
    wire running;
    wire stage_hold;
    wire twos;
    wire stab_on;
    reg [1:0] nxt_mode;
    reg [9:0] nxt_code;
    reg nxt_ovr;
    wire [9:0] corrected;
    wire [9:0] coded;
    wire bus_req;
    wire bus_done;
    wire [`EV_W-1:0] events;
    reg [`EV_W-1:0] nxt_status;
    wire [31:0] state_word;
    reg [31:0] nxt_rdata;
    wire ev_sample;
    wire ev_range;
    wire ev_mode;
    wire pins_drive;
    wire last_ovr;
    wire clr_hit;

    // power states, in the same codes as the state register field
    localparam ST_RUN = `MODE_NORMAL;
    localparam ST_NAP = `MODE_NAP;
    localparam ST_SLEEP = `MODE_SLEEP;

    assign phase_now = ENCODE_POS & ~ENCODE_NEG;
    assign rise = phase_now & ~phase_prev_ff;
    assign fall = ~phase_now & phase_prev_ff;
    assign running = (mode_ff == ST_RUN);
    // stages only move while converting; nap and sleep freeze the pipeline
    assign stage_hold = ~running;
    // outputs drive only in normal operation with the enable pin low
    assign pins_drive = ~POWER_DOWN_SELECT & ~OUTPUT_ENABLE_N;
    assign last_ovr = ovr_ff[`HALF_STEPS-1];

    assign twos = (CONFIG_LEVEL == `CFG_TC_ON) | (CONFIG_LEVEL == `CFG_TC_OFF);
    assign stab_on = (CONFIG_LEVEL == `CFG_OB_ON) | (CONFIG_LEVEL == `CFG_TC_ON);

    // the pins are static straps, so the state follows them one clock later
    always @* begin
        nxt_mode = ST_RUN;
        case ({POWER_DOWN_SELECT, OUTPUT_ENABLE_N})
            2'b10: begin
                nxt_mode = ST_NAP;
            end
            2'b11: begin
                nxt_mode = ST_SLEEP;
            end
            default: begin
                nxt_mode = ST_RUN;
            end
        endcase
    end

    // clamp the input into the offset-binary code space, flag out-of-range
    always @* begin
        nxt_ovr = 1'b0;
        nxt_code = ANALOG_IN[9:0] ^ `CODE_MID;
        if (ANALOG_IN > `CODE_MAX) begin
            nxt_ovr = 1'b1;
            nxt_code = {`WORD_W{1'b1}};
        end else if (ANALOG_IN < `CODE_MIN) begin
            nxt_ovr = 1'b1;
            nxt_code = {`WORD_W{1'b0}};
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            phase_prev_ff <= 1'b0;
            mode_ff <= ST_RUN;
        end else begin
            phase_prev_ff <= phase_now;
            mode_ff <= nxt_mode;
        end
    end

    // sampler follows the input while encode is low, frozen while high;
    // at a detected rise it still holds the last value tracked while low
    always @(posedge CLK) begin
        if (!RST_N) begin
            held_code_ff <= {`WORD_W{1'b0}};
            held_ovr_ff <= 1'b0;
        end else if (!phase_now && running) begin
            held_code_ff <= nxt_code;
            held_ovr_ff <= nxt_ovr;
        end
    end

    // half-step i loads on rise (even i) or fall (odd i): neighbours work in
    // opposite phases, each odd half-step resolving one digit of the word
    genvar i;
    generate
        for (i = 0; i < `HALF_STEPS; i = i + 1) begin : g_half
            if (i == 0) begin : g_first
                always @(posedge CLK) begin
                    if (!RST_N) begin
                        res_ff[i] <= {`WORD_W{1'b0}};
                        acc_ff[i] <= {`WORD_W{1'b0}};
                        ovr_ff[i] <= 1'b0;
                    end else if (!stage_hold && rise) begin
                        // frozen sample enters the first stage
                        res_ff[i] <= held_code_ff;
                        acc_ff[i] <= {`WORD_W{1'b0}};
                        ovr_ff[i] <= held_ovr_ff;
                    end
                end
            end else if ((i % 2) == 1) begin : g_resolve
                always @(posedge CLK) begin
                    if (!RST_N) begin
                        res_ff[i] <= {`WORD_W{1'b0}};
                        acc_ff[i] <= {`WORD_W{1'b0}};
                        ovr_ff[i] <= 1'b0;
                    end else if (!stage_hold && fall) begin
                        // stage quantizes its digit, residue shifted up
                        res_ff[i] <= {res_ff[i-1][7:0], 2'b00};
                        acc_ff[i] <= acc_ff[i-1] |
                            ({8'h00, res_ff[i-1][9:8]} << (8 - (i - 1)));
                        ovr_ff[i] <= ovr_ff[i-1];
                    end
                end
            end else begin : g_pass
                // residue handed on in the opposite phase to its neighbours
                always @(posedge CLK) begin
                    if (!RST_N) begin
                        res_ff[i] <= {`WORD_W{1'b0}};
                        acc_ff[i] <= {`WORD_W{1'b0}};
                        ovr_ff[i] <= 1'b0;
                    end else if (!stage_hold && rise) begin
                        res_ff[i] <= res_ff[i-1];
                        acc_ff[i] <= acc_ff[i-1];
                        ovr_ff[i] <= ovr_ff[i-1];
                    end
                end
            end
        end
    endgenerate

    assign corrected = acc_ff[`HALF_STEPS-1];
    assign coded = twos ? (corrected ^ `CODE_MID) : corrected;

    // word and flag are one register stage, loaded only on a detected rise
    always @(posedge CLK) begin
        if (!RST_N) begin
            SAMPLE_BITS <= {`WORD_W{1'b0}};
            RANGE_FLAG <= 1'b0;
        end else if (rise && running) begin
            // word and flag change together, fifth rise after sampling
            SAMPLE_BITS <= coded;
            RANGE_FLAG <= last_ovr;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            SAMPLE_STROBE <= 1'b0;
        end else begin
            // strobe falls mid-cycle while data is stable for the capture side
            SAMPLE_STROBE <= running & phase_now;
        end
    end

    // enables are registered so that every pin leaves a flip-flop
    always @(posedge CLK) begin
        if (!RST_N) begin
            SAMPLE_BITS_OE <= {`WORD_W{1'b0}};
            RANGE_FLAG_OE <= 1'b0;
            SAMPLE_STROBE_OE <= 1'b0;
        end else begin
            SAMPLE_BITS_OE <= {`WORD_W{pins_drive}};
            RANGE_FLAG_OE <= pins_drive;
            SAMPLE_STROBE_OE <= pins_drive;
        end
    end

    // register slave: one stall cycle, answer in the second
    assign bus_req = AVS_READ | AVS_WRITE;
    assign bus_done = bus_req & ~AVS_WAITREQUEST;
    assign ev_sample = rise & running;
    assign ev_range = rise & running & last_ovr;
    // a pin change that moves the power state is reported as well
    assign ev_mode = (nxt_mode != mode_ff);
    assign events = {ev_mode, ev_range, ev_sample};
    assign clr_hit = AVS_WRITE & bus_done & (AVS_ADDRESS == `REG_IRQ_CLR);
    assign state_word = {17'h00000, stab_on, twos, mode_ff, RANGE_FLAG, SAMPLE_BITS};

    always @* begin
        nxt_status = status_ff;
        if (clr_hit) begin
            nxt_status = status_ff & ~AVS_WRITEDATA[`EV_W-1:0];
        end
        // a new event wins over a clear in the same cycle
        nxt_status = nxt_status | events;
    end

    // unmapped offsets and the write-only clear register read as zero
    always @* begin
        nxt_rdata = 32'h00000000;
        case (AVS_ADDRESS)
            `REG_STATUS: begin
                nxt_rdata = {29'h00000000, status_ff};
            end
            `REG_IRQ_EN: begin
                nxt_rdata = {29'h00000000, irq_en_ff};
            end
            `REG_STATE: begin
                nxt_rdata = state_word;
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else begin
            // one stall cycle per request, then one answer cycle
            AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
            if (AVS_READ && AVS_WAITREQUEST) begin
                AVS_READDATA <= nxt_rdata;
            end
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            irq_en_ff <= {`EV_W{1'b0}};
        end else if (AVS_WRITE && bus_done && AVS_ADDRESS == `REG_IRQ_EN) begin
            irq_en_ff <= AVS_WRITEDATA[`EV_W-1:0];
        end
    end

    // the line is registered from the next status, so it never glitches
    always @(posedge CLK) begin
        if (!RST_N) begin
            status_ff <= {`EV_W{1'b0}};
            IRQ <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            IRQ <= |(nxt_status & irq_en_ff);
        end
    end
endmodule

// file: adc_output_control_props.sv
// property checker for the converter output control block
`timescale 1ns/1ps
module adc_output_control_props (
    input wire CLK, // clock
    input wire RST_N, // reset, low
    input wire ENCODE_POS, // encode +
    input wire ENCODE_NEG, // encode -
    input wire POWER_DOWN_SELECT, // power down
    input wire OUTPUT_ENABLE_N, // enable, low
    input wire [9:0] SAMPLE_BITS, // word
    input wire [9:0] SAMPLE_BITS_OE, // word enables
    input wire RANGE_FLAG, // range flag
    input wire RANGE_FLAG_OE, // flag enable
    input wire SAMPLE_STROBE, // strobe
    input wire SAMPLE_STROBE_OE, // strobe enable
    input wire AVS_READ, // read
    input wire AVS_WRITE, // write
    input wire AVS_WAITREQUEST // stall
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire phase = ENCODE_POS & ~ENCODE_NEG;
    wire run = ~POWER_DOWN_SELECT;
    sequence req_s;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    // the mode gate may lag the pin, so only judge after a settled stretch
    sequence run_s;
        run [*4];
    endsequence
    strobe_phase_a: assert property (run_s |-> SAMPLE_STROBE == $past(phase))
        else $error("strobe does not follow encode phase");
    drive_enable_a: assert property (SAMPLE_BITS_OE == {10{$past(run && !OUTPUT_ENABLE_N)}})
        else $error("word drive enable wrong");
    enable_tie_a: assert property (RANGE_FLAG_OE == SAMPLE_BITS_OE[0] && SAMPLE_STROBE_OE == SAMPLE_BITS_OE[9])
        else $error("drive enables disagree");
    word_sync_a: assert property (run_s ##0 $changed(SAMPLE_BITS) |-> $rose(SAMPLE_STROBE))
        else $error("word changed off the strobe rise");
    flag_sync_a: assert property (run_s ##0 $changed(RANGE_FLAG) |-> $rose(SAMPLE_STROBE))
        else $error("flag changed off the strobe rise");
    power_freeze_a: assert property (POWER_DOWN_SELECT [*4] |-> $stable(SAMPLE_BITS) && !SAMPLE_STROBE)
        else $error("outputs move in power down");
    power_hiz_a: assert property (POWER_DOWN_SELECT [*2] |-> SAMPLE_BITS_OE == 10'h000)
        else $error("outputs driven in power down");
    bus_answer_a: assert property (req_s |=> !AVS_WAITREQUEST)
        else $error("no answer one cycle after request");
    bus_release_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than a cycle");
endmodule
bind adc_output_control adc_output_control_props u_props (.CLK, .RST_N, .ENCODE_POS, .ENCODE_NEG,
    .POWER_DOWN_SELECT, .OUTPUT_ENABLE_N, .SAMPLE_BITS, .SAMPLE_BITS_OE, .RANGE_FLAG,
    .RANGE_FLAG_OE, .SAMPLE_STROBE, .SAMPLE_STROBE_OE, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST);

// file: sample_capture_model.sv
// capture logic model latching the word on the strobe falling edge
`timescale 1ns/1ps
module sample_capture_model (
    input wire clk, // clock
    input wire stb, // strobe
    input wire stb_oe, // strobe enable
    input wire [9:0] bits, // word
    input wire [9:0] bits_oe, // word enables
    input wire flag, // range flag
    input wire flag_oe, // flag enable
    output reg cap_stb = 1'b0, // capture pulse
    output reg [9:0] cap_word = 10'h000, // latched word
    output reg cap_flag = 1'b0 // latched flag
);
    reg stb_ff = 1'b0;
    reg [9:0] last_ff = 10'h000;
    reg flag_ff = 1'b0;
    // an undriven word or flag line flips each cycle so hi-z never passes for data; an undriven strobe reads low
    wire [9:0] bus_w = (bits & bits_oe) | (~last_ff & ~bits_oe);
    wire flag_w = flag_oe ? flag : ~flag_ff;
    wire stb_w = stb_oe & stb;
    always @(posedge clk) begin
        stb_ff <= stb_w;
        last_ff <= bus_w;
        flag_ff <= flag_w;
        cap_stb <= stb_ff & ~stb_w;
        if (stb_ff & ~stb_w) begin
            cap_word <= bus_w;
            cap_flag <= flag_w;
        end
    end
endmodule

// file: test_pipelined_adc_output_control.sv
// self-checking bench for the converter output control block
`timescale 1ns/1ps
module test_pipelined_adc_output_control;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg enc_p = 1'b0;
    reg enc_n = 1'b1;
    reg pds = 1'b0;
    reg oe_n = 1'b1;
    reg [1:0] cfg = 2'h0;
    reg signed [11:0] ain = 12'sh000;
    reg [3:0] addr = 4'h0;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdata = 32'h0;
    reg [31:0] got;
    reg [10:0] ex [0:127];
    wire [31:0] rdata;
    wire [9:0] bits, bits_oe, cap_word;
    wire flag, flag_oe, stb, stb_oe, wait_r, irq, cap_stb, cap_flag;
    integer seed = 32'h9896, err_total = 0, check_count = 0, rises = 0, caps = 0, i, b, n, k;
    always #2 clk = ~clk;
    adc_output_control u_dut (.CLK(clk), .RST_N(rst_n), .ENCODE_POS(enc_p), .ENCODE_NEG(enc_n),
        .ANALOG_IN(ain), .POWER_DOWN_SELECT(pds), .OUTPUT_ENABLE_N(oe_n), .CONFIG_LEVEL(cfg),
        .SAMPLE_BITS(bits), .SAMPLE_BITS_OE(bits_oe), .RANGE_FLAG(flag), .RANGE_FLAG_OE(flag_oe),
        .SAMPLE_STROBE(stb), .SAMPLE_STROBE_OE(stb_oe), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_r), .IRQ(irq));
    sample_capture_model u_cap (.clk(clk), .stb(stb), .stb_oe(stb_oe), .bits(bits),
        .bits_oe(bits_oe), .flag(flag), .flag_oe(flag_oe), .cap_stb(cap_stb),
        .cap_word(cap_word), .cap_flag(cap_flag));
    function [10:0] exp_of(input signed [11:0] a, input tc);
        reg signed [11:0] c;
        begin
            c = (a > 12'sh1ff) ? 12'sh1ff : (a < -12'sh200) ? -12'sh200 : a;
            exp_of = {c != a, c[9:0] ^ (tc ? 10'h000 : 10'h200)};
        end
    endfunction
    task chk(input [31:0] want, input [31:0] seen, input string what);
        begin
            check_count = check_count + 1;
            if (want !== seen) begin
                $display("BAD %0s want %h seen %h", what, want, seen);
                err_total = err_total + 1;
            end
        end
    endtask
    task bus(input w, input [3:0] a, input [31:0] d);
        begin
            rd <= ~w;
            wr <= w;
            addr <= a;
            wdata <= d;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (wait_r !== 1'b0 && n < 40);
            got = rdata;
            chk(32'h0, {31'h0, wait_r}, "waitrequest");
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task enc(input signed [11:0] v);
        reg [31:0] r;
        begin
            r = $random(seed);
            ain <= v;
            enc_p <= r[0];
            enc_n <= 1'b1;
            repeat (3) @(posedge clk);
            enc_p <= 1'b1;
            enc_n <= 1'b0;
            ex[rises] = exp_of(v, cfg[1]);
            rises = rises + 1;
            repeat (3) @(posedge clk);
        end
    endtask
    task idle;
        begin
            enc_p <= 1'b0;
            enc_n <= 1'b1;
            repeat (12) @(posedge clk);
        end
    endtask
    task wrap_up;
        begin
            if (err_total == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        if (cap_stb) begin
            if (caps % 16 >= 7 && caps < 64)
                chk({21'h0, ex[caps - 5]}, {21'h0, cap_flag, cap_word}, "sample");
            caps = caps + 1;
        end
    end
    initial begin
        #40000;
        chk(32'h0, 32'h1, "watchdog");
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        oe_n <= 1'b0;
        @(posedge clk);
        bus(1'b1, 4'h4, 32'h1);
        for (b = 0; b < 4; b = b + 1) begin
            cfg <= b[1:0];
            for (i = 0; i < 16; i = i + 1) begin
                k = $random(seed) % 640;
                enc(i == 8 ? 12'sh1ff : i == 9 ? 12'sh200 : i == 10 ? -12'sh200 : k[11:0]);
            end
            idle;
            chk(32'h1, {31'h0, irq}, "irq set");
            chk(32'h3ff, {22'h0, bits_oe}, "drive");
            bus(1'b0, 4'hc, 32'h0);
            chk({17'h0, b == 1 || b == 2, b[1], 2'h0, ex[rises - 6]}, {17'h0, got[14:0]}, "state");
            bus(1'b1, 4'h8, 32'h7);
            repeat (2) @(posedge clk);
            chk(32'h0, {31'h0, irq}, "irq clear");
        end
        bus(1'b1, 4'h4, 32'h0);
        enc(12'sh000);
        idle;
        chk(32'h0, {31'h0, irq}, "irq masked");
        bus(1'b0, 4'h0, 32'h0);
        chk(32'h1, {31'h0, got[0]}, "status");
        bus(1'b0, 4'h2, 32'h0);
        chk(32'h0, got, "unmapped");
        k = caps;
        pds <= 1'b1;
        enc(12'sh055);
        idle;
        bus(1'b0, 4'hc, 32'h0);
        chk(32'h1, {30'h0, got[12:11]}, "nap");
        oe_n <= 1'b1;
        enc(12'sh0aa);
        idle;
        bus(1'b0, 4'hc, 32'h0);
        chk(32'h2, {30'h0, got[12:11]}, "sleep");
        chk(k, caps, "frozen");
        wrap_up;
    end
endmodule
